/* rtl/reload_and_wakeup_timers_consts.svh */
/*
  Register offsets, field positions and fixed counts of the reload and
  wake-up timer block. Assumes an 8-bit register port with 8-bit addresses.
*/
`ifndef RELOAD_AND_WAKEUP_TIMERS_CONSTS_SVH
`define RELOAD_AND_WAKEUP_TIMERS_CONSTS_SVH

// ==========================================================================
// register offsets
`define ADDR_GEN_CTRL        8'h1e
`define ADDR_GEN_RELOAD_HI   8'h1f
`define ADDR_GEN_RELOAD_LO   8'h20
`define ADDR_GEN_COUNT_HI    8'h21
`define ADDR_GEN_COUNT_LO    8'h22
`define ADDR_WAKE_CTRL       8'h23
`define ADDR_WAKE_RELOAD_HI  8'h24
`define ADDR_WAKE_RELOAD_LO  8'h25
`define ADDR_WAKE_COUNT_HI   8'h26
`define ADDR_WAKE_COUNT_LO   8'h27
`define ADDR_TIMER_STATUS    8'h30
`define ADDR_TIMER_COMMAND   8'h31

// ==========================================================================
// field positions
`define WAKE_RUN_BIT         7
`define WAKE_STROBE_BIT      6
`define GEN_STOP_RX_BIT      7
`define STATUS_WAKE_FLAG_BIT 0
`define STATUS_GEN_FLAG_BIT  1
`define CMD_START_BIT        0
`define CMD_STOP_BIT         1

// ==========================================================================
// reset values and counts
`define RESET_BYTE           8'h00
`define RESET_WORD           16'h0000
`define COUNT_ONE            16'h0001
`define WAKE_DIV1_LAST       5'h00
`define WAKE_DIV8_LAST       5'h07
`define WAKE_DIV16_LAST      5'h0f
`define WAKE_DIV32_LAST      5'h1f

`endif

/* rtl/reload_and_wakeup_timers_pkg.sv */
/*
  Types of the reload and wake-up timer block: modes, control fields and
  the whole state of the block as one packed struct.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package reload_and_wakeup_timers_pkg;

  // ========================================================================
  // modes
  typedef enum logic [1:0] {
    GEN_START_NONE    = 2'b00,
    GEN_START_TX_END  = 2'b01,
    GEN_START_TRIM    = 2'b10,
    GEN_START_TRIM_UF = 2'b11
  } gen_start_mode_t;

  typedef enum logic [1:0] {
    LOW_POWER_CARD_DETECTION_IDLE    = 2'b00,
    LOW_POWER_CARD_DETECTION_FIELD   = 2'b01,
    LOW_POWER_CARD_DETECTION_VERDICT = 2'b10
  } low_power_card_detection_phase_t;

  // ========================================================================
  // control fields
  typedef struct packed {
    logic gen_timer_stop_on_receive;
    gen_start_mode_t gen_timer_start_mode;
    logic gen_timer_auto_reload;
    logic [1:0] gen_timer_clock_select;
  } gen_ctrl_t;

  typedef struct packed {
    logic wake_timer_auto_trim_enable;
    logic wake_timer_card_detect_enable;
    logic wake_timer_auto_reload;
    logic wake_timer_auto_resume;
    logic [1:0] wake_timer_clock_select;
  } wake_ctrl_t;

  // ========================================================================
  // whole block state
  typedef struct packed {
    logic [2:0] osc_sync;
    logic osc_lvl;
    gen_ctrl_t gen_ctrl;
    logic [15:0] gen_reload;
    logic [15:0] gen_count;
    logic gen_run;
    logic gen_trim_armed;
    wake_ctrl_t wake_ctrl;
    logic [15:0] wake_reload;
    logic [15:0] wake_count;
    logic wake_run;
    logic [4:0] prescale;
    logic wake_flag;
    logic gen_flag;
    low_power_card_detection_phase_t low_power_card_detection;
    logic [7:0] rd_data;
    logic gen_uf_pulse;
    logic trim_launch;
    logic low_power_card_detection_start;
    logic rf_on;
    logic card_irq;
    logic power_down_req;
    logic auto_wake;
  } state_t;

endpackage

/* rtl/reload_and_wakeup_timers.sv */
/*
  General 16-bit reload timer and 16-bit wake-up timer with register port,
  automatic trimming launch and low-power card detection sequencing.
  Assumes: tick inputs and event pulses are one-cycle pulses on i_ref_clk;
  the slow oscillator arrives asynchronously on i_slow_osc.
*/
// Overview of operation
// - general timer clock picked by two-bit selector
// - upper reload byte register, loaded at start
// - lower reload byte register, combined at load
// - reload writes never disturb running count
// - live count readable as two bytes
// - wake control bit 7 shows running
// - write-only bit 6 gates run change
// - wake underflow launches trimming when enabled
// - wake underflow starts card detection when enabled
// - card detection restarts wake countdown immediately
// - general timer sets RF field time
// - wake auto reload or card detection continues, else stops
// - wake underflow sets its interrupt flag
// - auto resume wakes device, permits power-down
// - wake clock undivided or divided 8/16/32
// - wake timer 16 bits, reload at start
// - start modes: none, tx end, trimming
// - general auto reload continues, else stops; trimming without underflow parks at zero, running
// - stop after four received bits unless trimming
`include "reload_and_wakeup_timers_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module reload_and_wakeup_timers (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // clock sources
  input wire logic i_slow_osc,
  input wire logic i_tick_13m56,
  input wire logic i_tick_211k,
  input wire logic i_timer0_underflow,
  input wire logic i_timer1_underflow,
  // link events
  input wire logic i_tx_end,
  input wire logic i_rx_4bits,
  input wire logic i_card_detected,
  input wire logic i_card_absent,
  // status and requests
  output logic o_wake_running,
  output logic o_wake_underflow_flag,
  output logic o_gen_underflow_flag,
  output logic o_gen_underflow,
  output logic o_trim_launch,
  output logic o_card_detect_start,
  output logic o_rf_field_on,
  output logic o_card_irq,
  output logic o_power_down_req,
  output logic o_auto_wake
);

  // ========================================================================
  // helpers
  function automatic logic [4:0] wake_div_last(input logic [1:0] sel);
    case (sel)
      2'b00: wake_div_last = `WAKE_DIV1_LAST;
      2'b01: wake_div_last = `WAKE_DIV8_LAST;
      2'b10: wake_div_last = `WAKE_DIV16_LAST;
      default: wake_div_last = `WAKE_DIV32_LAST;
    endcase
  endfunction

  function automatic logic is_trim(input reload_and_wakeup_timers_pkg::gen_start_mode_t m);
    is_trim = (m == reload_and_wakeup_timers_pkg::GEN_START_TRIM) ||
              (m == reload_and_wakeup_timers_pkg::GEN_START_TRIM_UF);
  endfunction

  reload_and_wakeup_timers_pkg::state_t r;
  reload_and_wakeup_timers_pkg::state_t n;

  logic osc_stable;
  logic osc_rise;
  logic ctrl_wr;
  logic trim_mode;
  logic wake_tick;
  logic wake_uf;
  logic gen_tick;
  logic gen_uf;
  logic gen_load;
  logic gen_halt;
  logic cmd_start;
  logic cmd_stop;
  logic clr_wake;
  logic clr_gen;

  // ========================================================================
  // next state
  always_comb begin
    n = r;
    n.gen_uf_pulse = 1'b0;
    n.trim_launch = 1'b0;
    n.low_power_card_detection_start = 1'b0;
    n.card_irq = 1'b0;
    n.power_down_req = 1'b0;
    n.auto_wake = 1'b0;

    // slow oscillator: three stages, a change counts once stages two and three agree
    n.osc_sync = {r.osc_sync[1:0], i_slow_osc};
    osc_stable = (r.osc_sync[1] == r.osc_sync[2]);
    osc_rise = osc_stable && r.osc_sync[2] && !r.osc_lvl;
    if (osc_stable) begin
      n.osc_lvl = r.osc_sync[2];
    end

    ctrl_wr = i_wr && (i_addr == `ADDR_WAKE_CTRL) && i_wr_data[`WAKE_STROBE_BIT];
    cmd_start = i_wr && (i_addr == `ADDR_TIMER_COMMAND) && i_wr_data[`CMD_START_BIT];
    cmd_stop = i_wr && (i_addr == `ADDR_TIMER_COMMAND) && i_wr_data[`CMD_STOP_BIT];
    clr_wake = i_wr && (i_addr == `ADDR_TIMER_STATUS) && i_wr_data[`STATUS_WAKE_FLAG_BIT];
    clr_gen = i_wr && (i_addr == `ADDR_TIMER_STATUS) && i_wr_data[`STATUS_GEN_FLAG_BIT];
    trim_mode = is_trim(r.gen_ctrl.gen_timer_start_mode);

    // register writes; reload bytes only stored, counters untouched
    if (i_wr) begin
      case (i_addr)
        `ADDR_GEN_CTRL: begin
          n.gen_ctrl = reload_and_wakeup_timers_pkg::gen_ctrl_t'(
            {i_wr_data[7], i_wr_data[5:4], i_wr_data[3], i_wr_data[1:0]});
        end
        `ADDR_GEN_RELOAD_HI: begin
          n.gen_reload[15:8] = i_wr_data;
        end
        `ADDR_GEN_RELOAD_LO: begin
          n.gen_reload[7:0] = i_wr_data;
        end
        `ADDR_WAKE_CTRL: begin
          n.wake_ctrl = reload_and_wakeup_timers_pkg::wake_ctrl_t'(i_wr_data[5:0]);
        end
        `ADDR_WAKE_RELOAD_HI: begin
          n.wake_reload[15:8] = i_wr_data;
        end
        `ADDR_WAKE_RELOAD_LO: begin
          n.wake_reload[7:0] = i_wr_data;
        end
        default: begin
        end
      endcase
    end

    // ======================================================================
    // wake-up timer
    wake_tick = r.wake_run && osc_rise && (r.prescale == wake_div_last(r.wake_ctrl.wake_timer_clock_select));
    wake_uf = wake_tick && (r.wake_count <= `COUNT_ONE);
    if (r.wake_run && osc_rise) begin
      n.prescale = wake_tick ? 5'h00 : r.prescale + 5'h01;
    end
    if (wake_uf) begin
      // card detection forces back-to-back periods with no idle gap
      if (r.wake_ctrl.wake_timer_auto_reload || r.wake_ctrl.wake_timer_card_detect_enable) begin
        n.wake_count = r.wake_reload;
      end else begin
        n.wake_count = `RESET_WORD;
        n.wake_run = 1'b0;
      end
      n.trim_launch = r.wake_ctrl.wake_timer_auto_trim_enable;
      n.low_power_card_detection_start = r.wake_ctrl.wake_timer_card_detect_enable;
      n.auto_wake = r.wake_ctrl.wake_timer_auto_resume;
    end else if (wake_tick) begin
      n.wake_count = r.wake_count - `COUNT_ONE;
    end
    // software start or stop wins over a same-cycle underflow
    if (ctrl_wr) begin
      n.wake_run = i_wr_data[`WAKE_RUN_BIT];
      if (i_wr_data[`WAKE_RUN_BIT]) begin
        n.wake_count = r.wake_reload;
        n.prescale = 5'h00;
      end
    end

    // ======================================================================
    // general timer
    case (r.gen_ctrl.gen_timer_clock_select)
      2'b00: gen_tick = i_tick_13m56;
      2'b01: gen_tick = i_tick_211k;
      2'b10: gen_tick = i_timer0_underflow;
      default: gen_tick = i_timer1_underflow;
    endcase
    // trimming without underflow parks at zero instead of reporting
    gen_uf = r.gen_run && gen_tick && (r.gen_count <= `COUNT_ONE) &&
             (r.gen_ctrl.gen_timer_start_mode != reload_and_wakeup_timers_pkg::GEN_START_TRIM);
    gen_load = (cmd_start && !trim_mode) ||
               ((r.gen_ctrl.gen_timer_start_mode == reload_and_wakeup_timers_pkg::GEN_START_TX_END) && i_tx_end) ||
               (wake_uf && r.wake_ctrl.wake_timer_card_detect_enable) ||
               (trim_mode && osc_rise && !r.gen_run && r.gen_trim_armed);
    gen_halt = cmd_stop ||
               (r.gen_ctrl.gen_timer_stop_on_receive && !trim_mode && i_rx_4bits) ||
               (trim_mode && osc_rise && r.gen_run);
    if (r.gen_run && gen_tick) begin
      if (r.gen_count <= `COUNT_ONE) begin
        if (gen_uf && r.gen_ctrl.gen_timer_auto_reload) begin
          n.gen_count = r.gen_reload;
        end else begin
          n.gen_count = `RESET_WORD;
          if (gen_uf) begin
            n.gen_run = 1'b0;
          end
        end
      end else begin
        n.gen_count = r.gen_count - `COUNT_ONE;
      end
    end
    if (gen_halt) begin
      n.gen_run = 1'b0;
    end
    if (gen_load) begin
      n.gen_count = r.gen_reload;
      n.gen_run = 1'b1;
    end
    // trimming waits armed for the next oscillator rising edge
    if ((cmd_start && trim_mode) || (wake_uf && r.wake_ctrl.wake_timer_auto_trim_enable)) begin
      n.gen_trim_armed = 1'b1;
    end else if (cmd_stop || (gen_load && trim_mode)) begin
      n.gen_trim_armed = 1'b0;
    end

    // ======================================================================
    // card detection sequence
    case (r.low_power_card_detection)
      reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_IDLE: begin
        if (wake_uf && r.wake_ctrl.wake_timer_card_detect_enable) begin
          n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_FIELD;
        end
      end
      reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_FIELD: begin
        if (gen_uf || gen_halt || !r.gen_run) begin
          n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_VERDICT;
        end
      end
      reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_VERDICT: begin
        if (i_card_detected) begin
          n.card_irq = 1'b1;
          n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_IDLE;
        end else if (i_card_absent) begin
          n.power_down_req = r.wake_ctrl.wake_timer_auto_resume;
          n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_IDLE;
        end
      end
      default: begin
        n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_IDLE;
      end
    endcase
    // a new wake underflow restarts the field phase from any phase
    if (wake_uf && r.wake_ctrl.wake_timer_card_detect_enable) begin
      n.low_power_card_detection = reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_FIELD;
    end
    n.rf_on = (n.low_power_card_detection == reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_FIELD);

    // ======================================================================
    // sticky flags: a same-cycle event beats the clear
    n.wake_flag = (r.wake_flag && !clr_wake) || wake_uf;
    n.gen_flag = (r.gen_flag && !clr_gen) || gen_uf;
    n.gen_uf_pulse = gen_uf;

    // read data stand for exactly one cycle
    n.rd_data = `RESET_BYTE;
    if (i_rd) begin
      case (i_addr)
        `ADDR_GEN_CTRL: n.rd_data = {r.gen_ctrl.gen_timer_stop_on_receive, 1'b0,
          r.gen_ctrl.gen_timer_start_mode, r.gen_ctrl.gen_timer_auto_reload, 1'b0,
          r.gen_ctrl.gen_timer_clock_select};
        `ADDR_GEN_RELOAD_HI: n.rd_data = r.gen_reload[15:8];
        `ADDR_GEN_RELOAD_LO: n.rd_data = r.gen_reload[7:0];
        `ADDR_GEN_COUNT_HI: n.rd_data = r.gen_count[15:8];
        `ADDR_GEN_COUNT_LO: n.rd_data = r.gen_count[7:0];
        `ADDR_WAKE_CTRL: n.rd_data = {r.wake_run, 1'b0, r.wake_ctrl};
        `ADDR_WAKE_RELOAD_HI: n.rd_data = r.wake_reload[15:8];
        `ADDR_WAKE_RELOAD_LO: n.rd_data = r.wake_reload[7:0];
        `ADDR_WAKE_COUNT_HI: n.rd_data = r.wake_count[15:8];
        `ADDR_WAKE_COUNT_LO: n.rd_data = r.wake_count[7:0];
        `ADDR_TIMER_STATUS: n.rd_data = {6'h00, r.gen_flag, r.wake_flag};
        default: n.rd_data = `RESET_BYTE;
      endcase
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_rd_data = r.rd_data;
  assign o_wake_running = r.wake_run;
  assign o_wake_underflow_flag = r.wake_flag;
  assign o_gen_underflow_flag = r.gen_flag;
  assign o_gen_underflow = r.gen_uf_pulse;
  assign o_trim_launch = r.trim_launch;
  assign o_card_detect_start = r.low_power_card_detection_start;
  assign o_rf_field_on = r.rf_on;
  assign o_card_irq = r.card_irq;
  assign o_power_down_req = r.power_down_req;
  assign o_auto_wake = r.auto_wake;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  chk_gen_clock_sel: assert property (
    r.gen_run && r.gen_ctrl.gen_timer_clock_select == 2'b10 && !i_timer0_underflow && !gen_load && !gen_halt
    |=> $stable(r.gen_count)) else $error("general timer moved without selected tick");
  chk_gen_load_word: assert property (
    gen_load |=> r.gen_run && r.gen_count == $past(r.gen_reload)) else $error("general timer load wrong");
  chk_reload_no_disturb: assert property (
    i_wr && (i_addr == `ADDR_GEN_RELOAD_HI || i_addr == `ADDR_GEN_RELOAD_LO) && !(r.gen_run && gen_tick) && !gen_load
    |=> $stable(r.gen_count)) else $error("reload write disturbed count");
  chk_count_read: assert property (
    i_rd && i_addr == `ADDR_GEN_COUNT_LO |=> o_rd_data == $past(r.gen_count[7:0]) ##1 ($past(i_rd) || o_rd_data == 8'h00))
    else $error("count readback wrong");
  chk_running_read: assert property (
    i_rd && i_addr == `ADDR_WAKE_CTRL |=> o_rd_data[7] == $past(r.wake_run) && !o_rd_data[6])
    else $error("running bit readback wrong");
  chk_run_gate: assert property (
    i_wr && i_addr == `ADDR_WAKE_CTRL && !i_wr_data[6] && !wake_uf |=> $stable(o_wake_running))
    else $error("running changed without strobe");
  chk_run_strobe: assert property (
    ctrl_wr |=> o_wake_running == $past(i_wr_data[7])) else $error("strobe did not set running");
  chk_trim_launch: assert property (
    wake_uf && r.wake_ctrl.wake_timer_auto_trim_enable |=> o_trim_launch && r.gen_trim_armed)
    else $error("trim launch missing");
  chk_card_detect: assert property (
    wake_uf && r.wake_ctrl.wake_timer_card_detect_enable |=> o_card_detect_start && o_rf_field_on && r.gen_run)
    else $error("card detection did not start");
  chk_wake_reload: assert property (
    wake_uf && (r.wake_ctrl.wake_timer_auto_reload || r.wake_ctrl.wake_timer_card_detect_enable) && !ctrl_wr
    |=> r.wake_run && r.wake_count == $past(r.wake_reload)) else $error("wake timer did not reload");
  chk_wake_stop: assert property (
    wake_uf && !r.wake_ctrl.wake_timer_auto_reload && !r.wake_ctrl.wake_timer_card_detect_enable && !ctrl_wr
    |=> !o_wake_running ##1 (!o_wake_running || $past(ctrl_wr))) else $error("wake timer did not stop");
  chk_wake_flag: assert property (
    wake_uf |=> o_wake_underflow_flag) else $error("wake flag not set");
  chk_auto_resume: assert property (
    wake_uf |=> o_auto_wake == $past(r.wake_ctrl.wake_timer_auto_resume)) else $error("auto wake wrong");
  chk_power_down: assert property (
    r.low_power_card_detection == reload_and_wakeup_timers_pkg::LOW_POWER_CARD_DETECTION_VERDICT && i_card_absent && !i_card_detected
    |=> o_power_down_req == $past(r.wake_ctrl.wake_timer_auto_resume)) else $error("power-down request wrong");
  chk_tx_start: assert property (
    r.gen_ctrl.gen_timer_start_mode == reload_and_wakeup_timers_pkg::GEN_START_TX_END && i_tx_end
    |=> r.gen_run) else $error("no start at end of transmission");
  chk_gen_reload: assert property (
    gen_uf && r.gen_ctrl.gen_timer_auto_reload && !gen_load && !gen_halt
    |=> r.gen_run && r.gen_count == $past(r.gen_reload)) else $error("general timer did not reload");
  chk_rx_stop: assert property (
    i_rx_4bits && r.gen_ctrl.gen_timer_stop_on_receive && !trim_mode && !gen_load |=> !r.gen_run)
    else $error("timer not stopped on receive");
  chk_gen_decrement: assert property (
    r.gen_run && gen_tick && r.gen_count > 16'h0001 && !gen_load && !gen_halt
    |=> r.gen_count == $past(r.gen_count) - 16'h0001) else $error("general timer decrement wrong");

endmodule

`default_nettype wire

/* sim/reload_and_wakeup_timers_bench.sv */
/*
  Self-checking bench of the reload and wake-up timer block.
  Assumes the register map and offsets of the block's constants header
  and a 125 MHz reference clock; the bench drives every input itself.
*/
`include "reload_and_wakeup_timers_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module reload_and_wakeup_timers_bench;
  // ==========================================================================
  // stimulus and observed signals
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_slow_osc = 1'b0;
  logic [3:0] src = 4'h0;
  // tx end, four bits received, card present, no card
  logic [3:0] ev = 4'h0;
  logic [7:0] o_rd_data;
  logic o_wake_running, o_wake_underflow_flag, o_gen_underflow_flag, o_gen_underflow, o_trim_launch;
  logic o_card_detect_start, o_rf_field_on, o_card_irq, o_power_down_req, o_auto_wake;
  int n_mismatch = 0;
  int checked = 0;
  int seen_trim = 0;
  int seen_low_power_card_detection = 0;
  int seen_wake = 0;

  reload_and_wakeup_timers uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_slow_osc(i_slow_osc),
    .i_tick_13m56(src[0]), .i_tick_211k(src[1]), .i_timer0_underflow(src[2]), .i_timer1_underflow(src[3]),
    .i_tx_end(ev[0]), .i_rx_4bits(ev[1]), .i_card_detected(ev[2]), .i_card_absent(ev[3]),
    .o_wake_running(o_wake_running), .o_wake_underflow_flag(o_wake_underflow_flag),
    .o_gen_underflow_flag(o_gen_underflow_flag), .o_gen_underflow(o_gen_underflow),
    .o_trim_launch(o_trim_launch), .o_card_detect_start(o_card_detect_start), .o_rf_field_on(o_rf_field_on),
    .o_card_irq(o_card_irq), .o_power_down_req(o_power_down_req), .o_auto_wake(o_auto_wake));

  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  // one-cycle request pulses are counted at the edge that ends them
  always @(posedge i_ref_clk) begin
    seen_trim <= seen_trim + int'(o_trim_launch);
    seen_low_power_card_detection <= seen_low_power_card_detection + int'(o_card_detect_start);
    seen_wake <= seen_wake + int'(o_auto_wake);
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask

  task automatic tick(input int s);
    @(posedge i_ref_clk);
    src[s] <= 1'b1;
    @(posedge i_ref_clk);
    src <= 4'h0;
    #1;
  endtask

  task automatic pulse(input int e);
    @(posedge i_ref_clk);
    ev[e] <= 1'b1;
    @(posedge i_ref_clk);
    ev <= 4'h0;
    #1;
  endtask

  // long enough for the three-stage synchroniser to settle each way
  task automatic osc_edge;
    @(posedge i_ref_clk);
    i_slow_osc <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    i_slow_osc <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 8'h1e; a <= 8'h27; a++) begin
      rd(8'(a), d);
      chk(d, 8'h00);
    end
    rd(8'h40, d);
    chk(d, 8'h00);
  endtask

  task automatic t_gen_clock;
    logic [7:0] d;
    for (int s = 0; s < 4; s++) begin
      wr(`ADDR_GEN_CTRL, 8'(s));
      wr(`ADDR_GEN_RELOAD_HI, 8'h01);
      wr(`ADDR_GEN_RELOAD_LO, 8'h12);
      wr(`ADDR_TIMER_COMMAND, 8'h01);
      rd(`ADDR_GEN_COUNT_HI, d);
      chk(d, 8'h01);
      rd(`ADDR_GEN_COUNT_LO, d);
      chk(d, 8'h12);
      tick((s + 1) % 4);
      rd(`ADDR_GEN_COUNT_LO, d);
      chk(d, 8'h12);
      tick(s);
      rd(`ADDR_GEN_COUNT_LO, d);
      chk(d, 8'h11);
      wr(`ADDR_TIMER_COMMAND, 8'h02);
    end
  endtask

  task automatic t_underflow;
    logic [7:0] d;
    wr(`ADDR_GEN_CTRL, 8'h00);
    wr(`ADDR_GEN_RELOAD_HI, 8'h00);
    wr(`ADDR_GEN_RELOAD_LO, 8'h02);
    wr(`ADDR_TIMER_COMMAND, 8'h01);
    tick(0);
    wr(`ADDR_GEN_RELOAD_LO, 8'h05);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h01);
    tick(0);
    chk(o_gen_underflow, 1'b1);
    chk(o_gen_underflow_flag, 1'b1);
    tick(0);
    chk(o_gen_underflow, 1'b0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h00);
    wr(`ADDR_GEN_CTRL, 8'h08);
    wr(`ADDR_TIMER_COMMAND, 8'h01);
    repeat (4) tick(0);
    chk(o_gen_underflow, 1'b0);
    tick(0);
    chk(o_gen_underflow, 1'b1);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h05);
    wr(`ADDR_TIMER_COMMAND, 8'h02);
    wr(`ADDR_TIMER_STATUS, 8'h02);
    #1 chk(o_gen_underflow_flag, 1'b0);
  endtask

  // counts are read once before and once after the four-bit event
  task automatic t_stop_rx;
    logic [7:0] d;
    wr(`ADDR_GEN_CTRL, 8'h90);
    wr(`ADDR_GEN_RELOAD_LO, 8'h04);
    pulse(0);
    tick(0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h03);
    pulse(1);
    tick(0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h03);
  endtask

  task automatic t_wake;
    logic [7:0] d;
    wr(`ADDR_WAKE_RELOAD_HI, 8'h00);
    wr(`ADDR_WAKE_RELOAD_LO, 8'h02);
    wr(`ADDR_WAKE_CTRL, 8'hc4);
    rd(`ADDR_WAKE_CTRL, d);
    chk(d, 8'h84);
    wr(`ADDR_WAKE_CTRL, 8'h04);
    #1 chk(o_wake_running, 1'b1);
    osc_edge();
    rd(`ADDR_WAKE_COUNT_LO, d);
    chk(d, 8'h01);
    osc_edge();
    chk(o_wake_underflow_flag, 1'b1);
    chk(o_wake_running, 1'b0);
    chk(16'(seen_wake), 16'h0001);
    wr(`ADDR_WAKE_CTRL, 8'hc9);
    repeat (7) osc_edge();
    rd(`ADDR_WAKE_COUNT_LO, d);
    chk(d, 8'h02);
    osc_edge();
    rd(`ADDR_WAKE_COUNT_LO, d);
    chk(d, 8'h01);
    wr(`ADDR_WAKE_CTRL, 8'h40);
    #1 chk(o_wake_running, 1'b0);
  endtask

  task automatic t_card;
    logic [7:0] d;
    wr(`ADDR_GEN_CTRL, 8'h00);
    wr(`ADDR_GEN_RELOAD_LO, 8'h02);
    wr(`ADDR_WAKE_RELOAD_LO, 8'h01);
    wr(`ADDR_WAKE_CTRL, 8'hd0);
    osc_edge();
    chk(o_rf_field_on, 1'b1);
    chk(o_wake_running, 1'b1);
    rd(`ADDR_WAKE_COUNT_LO, d);
    chk(d, 8'h01);
    tick(0);
    chk(o_rf_field_on, 1'b1);
    tick(0);
    repeat (2) @(posedge i_ref_clk);
    #1 chk(o_rf_field_on, 1'b0);
    pulse(2);
    chk(o_card_irq, 1'b1);
    chk(o_power_down_req, 1'b0);
    // second period: no card, auto resume permits power-down
    wr(`ADDR_WAKE_CTRL, 8'h14);
    osc_edge();
    repeat (2) tick(0);
    pulse(3);
    chk(o_power_down_req, 1'b1);
    chk(o_card_irq, 1'b0);
    chk(16'(seen_low_power_card_detection), 16'h0002);
    chk(16'(seen_wake), 16'h0002);
    wr(`ADDR_WAKE_CTRL, 8'h40);
  endtask

  // trimming mode is set before auto-trim, card detection stays off
  task automatic t_trim;
    logic [7:0] d;
    wr(`ADDR_TIMER_STATUS, 8'h03);
    wr(`ADDR_GEN_CTRL, 8'h20);
    wr(`ADDR_WAKE_CTRL, 8'he0);
    osc_edge();
    chk(16'(seen_trim), 16'h0001);
    chk(o_wake_running, 1'b0);
    osc_edge();
    tick(0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h01);
    tick(0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h00);
    chk(o_gen_underflow_flag, 1'b0);
    osc_edge();
    wr(`ADDR_GEN_CTRL, 8'h30);
    wr(`ADDR_TIMER_COMMAND, 8'h01);
    osc_edge();
    tick(0);
    osc_edge();
    tick(0);
    rd(`ADDR_GEN_COUNT_LO, d);
    chk(d, 8'h01);
    wr(`ADDR_TIMER_COMMAND, 8'h01);
    osc_edge();
    repeat (2) tick(0);
    chk(o_gen_underflow, 1'b1);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_gen_clock();
    t_underflow();
    t_stop_rx();
    t_wake();
    t_card();
    t_trim();
    report_and_stop();
  end

  // the tests need well under 5000 cycles
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule

`default_nettype wire
